// >>> core/fault_line_channel_response.sv
// fault-line qualification and per-channel shutdown / restart control
// assumes fault lines arrive asynchronously, low active, and that the power
// sequencer outside honours turn-on delay and ramp when it sees restart
// the command front end decodes register addresses onto CMD_SEL
`timescale 1ns/100ps
`default_nettype none
module fault_line_channel_response
    import fault_line_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [3:0] FAULT_LINE_IN_N,
    output logic [3:0] FAULT_LINE_OUT,
    output logic [3:0] FAULT_LINE_OE,
    input wire logic [7:0] CHAN_FAULTED_OFF,
    input wire logic [1:0] FAULT_LINE_DRIVE_ENABLE,
    input wire logic CMD_WRITE,
    input wire logic CMD_READ,
    input wire logic [1:0] CMD_SEL,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    input wire logic [7:0] STATUS_CLEAR,
    output logic [7:0] STATUS_FAULT_LINE_OFF,
    output logic HOST_ALERT_LINE_N,
    output logic [7:0] CHAN_ENABLE,
    output logic [7:0] CHAN_RESTART
);
    // ========================================================
    // response registers, indexed by selector: zone*2 + line
    logic [RESP_WIDTH-1:0] resp [4];
    // line order: 0 zone0 A, 1 zone0 B, 2 zone1 A, 3 zone1 B
    logic [3:0] sync1, sync2, sync3;
    logic [3:0] line_low;
    logic [QUAL_CNT_W-1:0] qual_cnt [4];
    logic [3:0] qualified;
    chan_state_t ch_state [8];
    logic [7:0] trip;
    // decode and helper terms
    logic [3:0] wr_hit;
    logic [RESP_WIDTH-1:0] rd_sel;
    logic [3:0] qual_done;
    logic [1:0] zone_pull;
    logic alert_cause;

    // ========================================================
    // command port: write decode and response registers
    // one strobe per register, so each entry keeps a flop of its own
    always_comb begin
        wr_hit = 4'h0;
        if (CMD_WRITE) begin
            wr_hit[CMD_SEL] = 1'b1;
        end
    end

    // register writes keep only the four channel bits; reserved bits are dropped
    generate
        for (genvar r = 0; r < 4; r++) begin : g_resp
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    resp[r] <= RESP_RESET[RESP_WIDTH-1:0];
                end else if (wr_hit[r]) begin
                    resp[r] <= CMD_WDATA[RESP_LSB +: RESP_WIDTH];
                end
            end
        end
    endgenerate

    // read mux on the selector codes; all four codes decode, so no default
    always_comb begin
        rd_sel = '0;
        unique case (CMD_SEL)
            SEL_ZONE0_LINE_A: begin
                rd_sel = resp[0];
            end
            SEL_ZONE0_LINE_B: begin
                rd_sel = resp[1];
            end
            SEL_ZONE1_LINE_A: begin
                rd_sel = resp[2];
            end
            SEL_ZONE1_LINE_B: begin
                rd_sel = resp[3];
            end
        endcase
    end

    // read data is registered and holds until the next read strobe
    // upper nibble is fixed at zero, whatever was written there
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_RDATA <= 8'h00;
        end else if (CMD_READ) begin
            CMD_RDATA <= {RESERVED_READ, rd_sel};
        end
    end

    // ========================================================
    // line input synchroniser: three flops per line
    // stages reset to the released level, so no false assertion follows reset
    generate
        for (genvar l = 0; l < 4; l++) begin : g_sync
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    sync1[l] <= 1'b1;
                    sync2[l] <= 1'b1;
                    sync3[l] <= 1'b1;
                end else begin
                    sync1[l] <= FAULT_LINE_IN_N[l];
                    sync2[l] <= sync1[l];
                    sync3[l] <= sync2[l];
                end
            end

            // filtered level moves only once stages 2 and 3 agree
            // this costs a cycle but rejects a stage that is still settling
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    line_low[l] <= 1'b0;
                end else if (sync2[l] == sync3[l]) begin
                    line_low[l] <= ~sync3[l]; // low means asserted
                end
            end
        end
    endgenerate

    // ========================================================
    // per-line 10 us qualification; a short pulse restarts the count
    generate
        for (genvar l = 0; l < 4; l++) begin : g_line
            // terminal count: the line has now been low for the full 10 us
            assign qual_done[l] = (qual_cnt[l] >= QUALIFY_COUNT - 1'b1);

            // low-time counter; parks at terminal count so it can never wrap
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    qual_cnt[l] <= '0;
                end else if (!line_low[l]) begin
                    qual_cnt[l] <= '0;
                end else if (!qual_done[l]) begin
                    qual_cnt[l] <= qual_cnt[l] + 1'b1;
                end
            end

            // qualified flag stands while the line stays low past the count
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    qualified[l] <= 1'b0;
                end else if (!line_low[l]) begin
                    qualified[l] <= 1'b0;
                end else if (qual_done[l]) begin
                    qualified[l] <= 1'b1;
                end
            end
        end
    endgenerate

    // ========================================================
    // per-channel shutdown and restart
    generate
        for (genvar c = 0; c < 8; c++) begin : g_chan
            localparam int Z = c / 4;
            localparam int B = c % 4;
            // zone z line A is index 2z, line B is 2z+1; bit B maps to channel 4z+B
            logic hit_a, hit_b, held;
            assign hit_a = resp[2*Z][B] & qualified[2*Z];
            assign hit_b = resp[2*Z+1][B] & qualified[2*Z+1];
            // a cleared bit never lets its line through
            assign held = (resp[2*Z][B] & line_low[2*Z]) | (resp[2*Z+1][B] & line_low[2*Z+1]);
            assign trip[c] = hit_a | hit_b;

            // channel state: run, off while any watched line holds, one restart cycle
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    ch_state[c] <= CH_RUN;
                end else begin
                    unique case (ch_state[c])
                        CH_RUN: begin
                            if (trip[c]) begin
                                ch_state[c] <= CH_OFF;
                            end
                        end
                        CH_OFF: begin
                            // stays off while any enabled watched line is still low
                            if (!held) begin
                                ch_state[c] <= CH_RESTART;
                            end
                        end
                        CH_RESTART: begin
                            ch_state[c] <= CH_RUN;
                        end
                        default: begin
                            ch_state[c] <= CH_RUN;
                        end
                    endcase
                end
            end

            // enable falls on the trip and rises when the watched lines release
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    CHAN_ENABLE[c] <= 1'b1;
                end else begin
                    unique case (ch_state[c])
                        CH_RUN: begin
                            if (trip[c]) begin
                                CHAN_ENABLE[c] <= 1'b0;
                            end
                        end
                        CH_OFF: begin
                            if (!held) begin
                                CHAN_ENABLE[c] <= 1'b1;
                            end
                        end
                        CH_RESTART: begin
                            CHAN_ENABLE[c] <= 1'b1;
                        end
                        default: begin
                            CHAN_ENABLE[c] <= 1'b1;
                        end
                    endcase
                end
            end

            // restart is a one-cycle request; the sequencer applies delay and ramp
            // the block does not time them itself, so it needs no ramp counters
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    CHAN_RESTART[c] <= 1'b0;
                end else if (ch_state[c] == CH_OFF && !held) begin
                    CHAN_RESTART[c] <= 1'b1;
                end else begin
                    CHAN_RESTART[c] <= 1'b0;
                end
            end

            // sticky status: a new trip beats a clear in the same cycle
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    STATUS_FAULT_LINE_OFF[c] <= 1'b0;
                end else if (trip[c] && ch_state[c] == CH_RUN) begin
                    STATUS_FAULT_LINE_OFF[c] <= 1'b1;
                end else if (STATUS_CLEAR[c]) begin
                    STATUS_FAULT_LINE_OFF[c] <= 1'b0;
                end
            end
        end
    endgenerate

    // ========================================================
    // alert cause: any pending status bit, or a trip on any channel, which stands while its line stays qualified low
    // the trip term lets alert fall on the same edge as the enable
    assign alert_cause = |(STATUS_FAULT_LINE_OFF | trip);

    // alert is low active and registered so the pin never glitches
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_ALERT_LINE_N <= 1'b1;
        end else begin
            HOST_ALERT_LINE_N <= ~alert_cause;
        end
    end

    // zone pull request: any faulted-off channel of the zone, if propagation is on
    generate
        for (genvar z = 0; z < 2; z++) begin : g_zone
            assign zone_pull[z] = FAULT_LINE_DRIVE_ENABLE[z] & (|CHAN_FAULTED_OFF[4*z +: 4]);
        end
    endgenerate

    // open-drain data: the pin is only ever pulled low, never driven high
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FAULT_LINE_OUT <= 4'h0;
        end else begin
            FAULT_LINE_OUT <= 4'h0;
        end
    end

    // output enable per line; both lines of a zone carry the zone's fault
    generate
        for (genvar l = 0; l < 4; l++) begin : g_drive
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    FAULT_LINE_OE[l] <= 1'b0;
                end else begin
                    FAULT_LINE_OE[l] <= zone_pull[l / 2];
                end
            end
        end
    endgenerate
endmodule : fault_line_channel_response
`default_nettype wire

// >>> core/fault_line_pkg.sv
// constants for the fault-line channel response block
// assumes a 50 MHz core clock and a serial command front end outside this block
package fault_line_pkg;
    // ========================================================
    // register selectors on the command port
    localparam logic [1:0] SEL_ZONE0_LINE_A = 2'h0;
    localparam logic [1:0] SEL_ZONE0_LINE_B = 2'h1;
    localparam logic [1:0] SEL_ZONE1_LINE_A = 2'h2;
    localparam logic [1:0] SEL_ZONE1_LINE_B = 2'h3;
    // ========================================================
    // field layout and reset values
    localparam int RESP_LSB = 0;
    localparam int RESP_WIDTH = 4;
    localparam logic [7:0] RESP_RESET = 8'h00;
    localparam logic [3:0] RESERVED_READ = 4'h0;
    // ========================================================
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int QUALIFY_NS = 10000;
    localparam int QUALIFY_CYCLES = (QUALIFY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int QUAL_CNT_W = 10;
    localparam logic [QUAL_CNT_W-1:0] QUALIFY_COUNT = QUAL_CNT_W'(QUALIFY_CYCLES);
    // ========================================================
    // per-channel response states
    typedef enum logic [2:0] {
        CH_RUN = 3'b001,
        CH_OFF = 3'b010,
        CH_RESTART = 3'b100
    } chan_state_t;
endpackage : fault_line_pkg

// >>> bench/fault_line_channel_response_properties.sv
// port checker for the fault-line response block
// assumes it is bound onto the block and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module fault_line_channel_response_properties (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [3:0] FAULT_LINE_IN_N,
    input wire logic [3:0] FAULT_LINE_OUT,
    input wire logic [3:0] FAULT_LINE_OE,
    input wire logic [7:0] CHAN_FAULTED_OFF,
    input wire logic [1:0] FAULT_LINE_DRIVE_ENABLE,
    input wire logic CMD_READ,
    input wire logic [7:0] CMD_RDATA,
    input wire logic [7:0] STATUS_FAULT_LINE_OFF,
    input wire logic HOST_ALERT_LINE_N,
    input wire logic [7:0] CHAN_ENABLE,
    input wire logic [7:0] CHAN_RESTART
);
    // ====================
    // helpers
    logic [9:0] run [4];
    logic [7:0] held;
    logic [3:0] oe_want;
    logic any_st;
    // low run per line; saturates so a stuck line never wraps
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run <= '{default: '0};
        end else begin
            for (int i = 0; i < 4; i++) begin
                run[i] <= FAULT_LINE_IN_N[i] ? 10'h0 : run[i] + 10'(run[i] != 10'h3ff);
            end
        end
    end
    // slack of three cycles covers the input filter
    assign held = {{4{run[2] > 10'd496 || run[3] > 10'd496}}, {4{run[0] > 10'd496 || run[1] > 10'd496}}};
    assign oe_want = {{2{|CHAN_FAULTED_OFF[7:4] & FAULT_LINE_DRIVE_ENABLE[1]}},
                      {2{|CHAN_FAULTED_OFF[3:0] & FAULT_LINE_DRIVE_ENABLE[0]}}};
    assign any_st = |STATUS_FAULT_LINE_OFF;
    // ====================
    // properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    AST_RSV_ZERO: assert property (CMD_READ |=> CMD_RDATA[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    AST_RDATA_HOLD: assert property (!CMD_READ |=> $stable(CMD_RDATA))
        else $error("read data moved without read");
    AST_DRIVE_LOW: assert property (FAULT_LINE_OUT == 4'h0)
        else $error("fault line driven high");
    AST_PROPAGATE: assert property (FAULT_LINE_OE == $past(oe_want))
        else $error("line enable wrong");
    AST_QUALIFY: assert property (($past(CHAN_ENABLE) & ~CHAN_ENABLE & ~held) == 8'h0)
        else $error("channel off without held fault");
    AST_STATUS_SET: assert property (($past(CHAN_ENABLE) & ~CHAN_ENABLE & ~STATUS_FAULT_LINE_OFF) == 8'h0)
        else $error("shutdown without status");
    AST_ALERT: assert property ($rose(any_st) |=> !HOST_ALERT_LINE_N)
        else $error("alert not raised");
    AST_RESTART: assert property ((CHAN_ENABLE & ~$past(CHAN_ENABLE)) == CHAN_RESTART)
        else $error("restart pulse wrong");
    cover property (CHAN_RESTART != 8'h00);
    cover property (!HOST_ALERT_LINE_N);
    cover property (FAULT_LINE_OE != 4'h0);
endmodule : fault_line_channel_response_properties
bind fault_line_channel_response fault_line_channel_response_properties chk (.CLK, .ARST_N, .FAULT_LINE_IN_N,
    .FAULT_LINE_OUT, .FAULT_LINE_OE, .CHAN_FAULTED_OFF, .FAULT_LINE_DRIVE_ENABLE, .CMD_READ, .CMD_RDATA,
    .STATUS_FAULT_LINE_OFF, .HOST_ALERT_LINE_N, .CHAN_ENABLE, .CHAN_RESTART);
`default_nettype wire

// >>> bench/fault_line_peer.sv
// peer managers on the four shared fault lines
// assumes pull-ups on the lines; the bench says how long peers pull
`timescale 1ns/100ps
`default_nettype none
module fault_line_peer (
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] pull,
    output logic [3:0] line_n
);
    // wired-and: any party pulling low wins, else pull-up
    assign line_n = ~pull & ~(dev_oe & ~dev_out);
endmodule : fault_line_peer
`default_nettype wire

// >>> bench/fault_line_channel_response_tb_top.sv
// bench for the fault-line response block
// assumes the peer model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module fault_line_channel_response_tb_top;
    import fault_line_pkg::*;
    logic clk = 0, arst_n = 0, cmd_write = 0, cmd_read = 0, alert_n;
    logic [1:0] cmd_sel = 0, drive_en = 0;
    logic [3:0] pull = 0, line_n, f_out, f_oe;
    logic [7:0] wdata = 0, rdata, faulted = 0, st_clr = 0, status, chan_en, chan_rs, rs_seen;
    logic [7:0] shadow [4];
    int bad_count = 0, num_checks = 0, seed = 19354;
    fault_line_channel_response dut (.CLK(clk), .ARST_N(arst_n), .FAULT_LINE_IN_N(line_n), .FAULT_LINE_OUT(f_out),
        .FAULT_LINE_OE(f_oe), .CHAN_FAULTED_OFF(faulted), .FAULT_LINE_DRIVE_ENABLE(drive_en), .CMD_WRITE(cmd_write),
        .CMD_READ(cmd_read), .CMD_SEL(cmd_sel), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .STATUS_CLEAR(st_clr),
        .STATUS_FAULT_LINE_OFF(status), .HOST_ALERT_LINE_N(alert_n), .CHAN_ENABLE(chan_en), .CHAN_RESTART(chan_rs));
    fault_line_peer peer (.dev_out(f_out), .dev_oe(f_oe), .pull(pull), .line_n(line_n));
    // ====================
    // helpers
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one-cycle register access; ends mid-cycle so the next edge is free
    task automatic reg_op(input logic wr, input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk);
        cmd_write <= wr;
        cmd_read <= !wr;
        cmd_sel <= sel;
        wdata <= d;
        @(posedge clk);
        cmd_write <= 1'b0;
        cmd_read <= 1'b0;
        @(negedge clk);
    endtask : reg_op
    // zone 1 lines map onto the upper nibble
    function automatic logic [7:0] shut_mask(input int ln);
        return ln >= 2 ? {shadow[ln][3:0], 4'h0} : {4'h0, shadow[ln][3:0]};
    endfunction : shut_mask
    task automatic end_sim();
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // ====================
    // clock, watchdog, tests
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            reg_op(1'b0, 2'(i), 8'h00);
            cmp(rdata, RESP_RESET);
            shadow[i] = (i == 0) ? 8'hf5 : 8'($random(seed));
            reg_op(1'b1, 2'(i), shadow[i]);
            reg_op(1'b0, 2'(i), 8'h00);
            cmp(rdata, {RESERVED_READ, shadow[i][3:0]});
        end
        // glitch shorter than the qualify time must be ignored
        @(posedge clk);
        pull <= 4'h1;
        repeat (300) @(posedge clk);
        pull <= 4'h0;
        repeat (10) @(negedge clk);
        cmp(chan_en, 8'hff);
        cmp(status, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pull <= 4'(1 << i);
            repeat (520) @(negedge clk);
            cmp(chan_en, ~shut_mask(i));
            cmp(status, shut_mask(i));
            cmp({7'h0, alert_n}, {7'h0, shut_mask(i) == 8'h0});
            @(posedge clk);
            pull <= 4'h0;
            rs_seen = 8'h00;
            repeat (10) begin
                @(negedge clk);
                rs_seen |= chan_rs;
            end
            cmp(rs_seen, shut_mask(i));
            @(posedge clk);
            st_clr <= 8'hff;
            @(posedge clk);
            st_clr <= 8'h00;
            repeat (3) @(negedge clk);
            cmp(chan_en, 8'hff);
            cmp({7'h0, alert_n}, 8'h01);
        end
        // a clear held across the shutdown edge must lose to the new trip
        @(posedge clk);
        st_clr <= 8'hff;
        pull <= 4'h1;
        rs_seen = 8'h00;
        repeat (520) begin
            @(negedge clk);
            rs_seen |= status;
        end
        cmp(rs_seen, shut_mask(0));
        cmp(status, 8'h00);
        cmp(chan_en, ~shut_mask(0));
        cmp({7'h0, alert_n}, 8'h00);
        @(posedge clk);
        pull <= 4'h0;
        st_clr <= 8'h00;
        repeat (10) @(negedge clk);
        cmp(chan_en, 8'hff);
        cmp({7'h0, alert_n}, 8'h01);
        @(posedge clk);
        faulted <= 8'h11;
        drive_en <= 2'h2;
        repeat (3) @(negedge clk);
        cmp({4'h0, f_oe}, 8'h0c);
        cmp({4'h0, line_n}, 8'h03);
        end_sim();
    end
endmodule : fault_line_channel_response_tb_top
`default_nettype wire
